// File: bench/aux_starter_model.sv
// Behavioural model of the relay-driven starters of the auxiliary motors.
// Assumes relay levels high for run, on the block's clock.
module aux_starter_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [2:0] aux_motor_on,
    output logic [2:0]      running
);
    logic [2:0] pick_r;

    // A contactor pulls in two cycles after its relay closes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pick_r  <= 3'h0;
            running <= 3'h0;
        end else begin
            pick_r  <= aux_motor_on;
            running <= pick_r;
        end
    end
endmodule : aux_starter_model

// File: bench/pump_fan_staging_bench.sv
// Self-checking bench of the staging block, driving its AHB-Lite slave.
// Assumes the design's register map and a 4-cycle millisecond tick.
`include "staging_params.svh"
module pump_fan_staging_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP_F = `RST_ON_THR - `RST_OFF_THR;
    logic               hclk = 1'b0;
    logic               hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]        haddr, hwdata, hrdata;
    logic [1:0]         htrans;
    logic [15:0]        out_freq;
    logic [2:0]         aux_motor_on, running;
    logic signed [17:0] freq_offset;
    logic [17:0]        process_reference;
    int                 mismatches, n_compared;

    // Clock at 40 MHz.
    always #12.5 hclk = ~hclk;

    pump_fan_staging #(.TICK_CYCLES(16'h0004)) u_pump_fan_staging (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .out_freq(out_freq),
        .aux_motor_on(aux_motor_on), .freq_offset(freq_offset), .process_reference(process_reference));
    aux_starter_model u_aux_starter_model (
        .hclk(hclk), .hresetn(hresetn), .aux_motor_on(aux_motor_on), .running(running));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd

    task automatic setf(input logic [15:0] f);
        @(posedge hclk);
        out_freq <= f;
    endtask : setf

    task automatic idle(input int n);
        repeat (n) @(negedge hclk);
    endtask : idle

    task automatic wait_aux(input logic [2:0] exp);
        for (int i = 0; i < 400 && aux_motor_on !== exp; i++) @(negedge hclk);
        chk({29'h0, aux_motor_on}, {29'h0, exp});
    endtask : wait_aux

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        tally_and_finish();
    end

    // Reset, then the staging sequence up to three motors and back down.
    initial begin
        {hresetn, hsel, htrans, hwrite, haddr, hwdata, out_freq} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h04, `RST_ON_THR);
        rd(8'h10, `RST_OFF_THR);
        rd(8'h1c, `RST_DELAY);
        rd(8'h24, `RST_STEP);
        rd(8'h3c, 32'h0);
        $display("test reset values done");
        wr(8'h1c, 32'h2);
        wr(8'h20, 32'h2);
        wr(8'h24, 32'h0a);
        wr(8'h28, 32'h14);
        wr(8'h2c, 32'h1e);
        rd(8'h2c, 32'h1e);
        wr(8'h18, `RST_OFF_THR);
        rd(8'h18, `RST_OFF_THR);
        wr(8'h00, 32'h1);
        setf(16'd460);
        idle(40);
        chk({29'h0, aux_motor_on}, 32'h0);
        setf(16'd461);
        wait_aux(3'h1);
        chk(32'(freq_offset), 32'(-STEP_F));
        idle(2);
        chk({14'h0, process_reference}, 32'd510);
        setf(16'd440);
        idle(40);
        chk({29'h0, aux_motor_on}, 32'h1);
        wr(8'h34, 32'h7f);
        rd(8'h34, 32'h5);
        $display("test first stage and abort done");
        setf(16'd461);
        wait_aux(3'h3);
        chk(32'(freq_offset), 32'(-2 * STEP_F));
        idle(2);
        chk({14'h0, process_reference}, 32'd530);
        wait_aux(3'h7);
        chk(32'(freq_offset), 32'(-3 * STEP_F));
        idle(60);
        chk({14'h0, process_reference}, 32'd560);
        chk({29'h0, running}, 32'h7);
        $display("test three stages done");
        setf(16'd289);
        wait_aux(3'h3);
        chk(32'(freq_offset), 32'(-2 * STEP_F));
        wait_aux(3'h0);
        chk(32'(freq_offset), 32'h0);
        idle(2);
        chk({14'h0, process_reference}, 32'd500);
        $display("test destaging done");
        setf(16'd461);
        wait_aux(3'h1);
        wr(8'h00, 32'h0);
        wait_aux(3'h0);
        chk(32'(freq_offset), 32'h0);
        idle(2);
        chk({14'h0, process_reference}, 32'd500);
        $display("test disable done");
        tally_and_finish();
    end
endmodule : pump_fan_staging_bench

// File: bench/pump_fan_staging_sva.sv
// Checker of the staging block, watching its top-level ports only.
// Assumes one clock domain, hclk, with the active-low reset hresetn.
module staging_checker #(
    parameter logic [15:0] TICK_CYCLES = 16'h0004
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hreadyout,
    input  wire logic               hresp,
    input  wire logic [2:0]         aux_motor_on,
    input  wire logic signed [17:0] freq_offset
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Relays only ever show no motor, the first, the first two or all three motors.
    property p_relay_order; aux_motor_on inside {3'h0, 3'h1, 3'h3, 3'h7}; endproperty
    a_relay_order: assert property (p_relay_order)
        else $error("relay pattern out of order");
    property p_one_up;
        (aux_motor_on > $past(aux_motor_on)) |-> (aux_motor_on == {$past(aux_motor_on[1:0]), 1'b1});
    endproperty
    a_one_up: assert property (p_one_up)
        else $error("more than one motor added");
    // Starting a motor lowers the offset, stopping one raises it.
    property p_start_lowers; (aux_motor_on > $past(aux_motor_on)) |-> (freq_offset < $past(freq_offset)); endproperty
    a_start_lowers: assert property (p_start_lowers)
        else $error("start did not lower frequency");
    property p_stop_raises; (aux_motor_on < $past(aux_motor_on)) |-> (freq_offset > $past(freq_offset)); endproperty
    a_stop_raises: assert property (p_stop_raises)
        else $error("stop did not raise frequency");
    property p_idle_offset; (aux_motor_on == 3'h0) |-> (freq_offset == 18'sh0); endproperty
    a_idle_offset: assert property (p_idle_offset)
        else $error("offset left with no motor");
    // A change while enabled needs a fresh delay, so two changes come on adjacent edges only when enable drops on the edge of a change.
    property p_settle; (aux_motor_on != $past(aux_motor_on)) |=> $stable(aux_motor_on); endproperty
    a_settle: assert property (p_settle)
        else $error("motors changed on adjacent edges");
    // The bus slave never stalls and always answers OKAY.
    property p_bus_ready; hreadyout; endproperty
    a_bus_ready: assert property (p_bus_ready)
        else $error("slave inserted a wait state");
    property p_bus_okay; !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("slave gave an error response");
endmodule : staging_checker

bind pump_fan_staging staging_checker #(.TICK_CYCLES(TICK_CYCLES)) u_staging_checker (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .aux_motor_on(aux_motor_on), .freq_offset(freq_offset));

// File: src/pump_fan_staging.sv
// Pump and fan staging controller with its AHB-Lite register slave.
// Assumes the drive's output frequency arrives on the same clock, in 0.1 Hz
// units, and that the frequency offset and reference are applied downstream.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`include "staging_params.svh"

module pump_fan_staging #(
    parameter logic [15:0] TICK_CYCLES = 16'(`TICK_TIME_NS / `CLK_PERIOD_NS)
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,
    input  wire logic [15:0]        out_freq,
    output logic [2:0]              aux_motor_on,
    output logic signed [17:0]      freq_offset,
    output logic [17:0]             process_reference
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Picks one of three stage values by stage index.
    function automatic staging_pkg::freq_type sel3(
        input logic [1:0]             idx,
        input staging_pkg::freq_type  a,
        input staging_pkg::freq_type  b,
        input staging_pkg::freq_type  c
    );
        case (idx)
            2'h0:    sel3 = a;
            2'h1:    sel3 = b;
            default: sel3 = c;
        endcase
    endfunction : sel3

    // True when frequency is above threshold plus the hysteresis band.
    function automatic logic above_band(input logic [15:0] f, input logic [15:0] t);
        above_band = {1'b0, f} > ({1'b0, t} + `FREQ_HYST);
    endfunction : above_band

    // True when frequency is below threshold minus the hysteresis band.
    function automatic logic below_band(input logic [15:0] f, input logic [15:0] t);
        below_band = ({1'b0, f} + `FREQ_HYST) < {1'b0, t};
    endfunction : below_band

    // Signed width of one stage: on threshold minus off threshold.
    function automatic logic signed [17:0] stage_span(input logic [15:0] on_t, input logic [15:0] off_t);
        stage_span = $signed({2'b00, on_t}) - $signed({2'b00, off_t});
    endfunction : stage_span

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic                          enable_r;
    staging_pkg::freq_type         on_thr_r   [3];
    staging_pkg::freq_type         off_thr_r  [3];
    staging_pkg::freq_type         step_r     [3];
    logic [15:0]                   on_delay_r;
    logic [15:0]                   off_delay_r;
    staging_pkg::freq_type         setpoint_r;

    // Bus pipeline state.
    logic                          wr_pend_r;
    logic [7:0]                    wr_addr_r;
    logic                          hreadyout_r;
    logic                          hresp_r;
    logic [31:0]                   hrdata_r;
    logic [31:0]                   rd_data;

    // Staging state.
    staging_pkg::stage_state_type  state_r;
    staging_pkg::stage_state_type  state_nxt;
    logic [1:0]                    count_r;
    logic [1:0]                    count_nxt;
    logic [2:0]                    aux_r;
    logic [2:0]                    aux_nxt;
    logic signed [17:0]            offset_r;
    logic signed [17:0]            offset_nxt;
    logic [17:0]                   ref_r;
    logic [17:0]                   ref_nxt;
    logic [15:0]                   tick_cnt_r;
    logic                          tick_r;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Address phase acceptance and the write strobes of the data phase.
    logic       addr_ok;
    logic       wr_take;
    logic       rd_take;
    logic [7:0] addr_low;
    logic       we_ctrl;
    logic       we_on_dly;
    logic       we_off_dly;
    logic       we_setpt;
    logic [1:0] wr_idx;
    logic       we_on_thr;
    logic       we_off_thr;
    logic       we_step;

    assign addr_ok    = hsel & hready & htrans[1];
    assign wr_take    = addr_ok & hwrite & (hsize == `HSIZE_WORD);
    assign rd_take    = addr_ok & ~hwrite;
    assign addr_low   = haddr[7:0];
    assign we_ctrl    = wr_pend_r & (wr_addr_r == `ADDR_CTRL);
    assign we_on_dly  = wr_pend_r & (wr_addr_r == `ADDR_ON_DELAY);
    assign we_off_dly = wr_pend_r & (wr_addr_r == `ADDR_OFF_DELAY);
    assign we_setpt   = wr_pend_r & (wr_addr_r == `ADDR_SETPOINT);
    assign we_on_thr  = wr_pend_r & (wr_addr_r >= `ADDR_ON_THR1) & (wr_addr_r <= `ADDR_ON_THR3);
    assign we_off_thr = wr_pend_r & (wr_addr_r >= `ADDR_OFF_THR1) & (wr_addr_r <= `ADDR_OFF_THR3);
    assign we_step    = wr_pend_r & (wr_addr_r >= `ADDR_STEP1) & (wr_addr_r <= `ADDR_STEP3);
    assign wr_idx     = we_on_thr  ? 2'((wr_addr_r - `ADDR_ON_THR1) >> 2) :
                        we_off_thr ? 2'((wr_addr_r - `ADDR_OFF_THR1) >> 2) :
                                     2'((wr_addr_r - `ADDR_STEP1) >> 2);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; a write still in its data phase is forwarded to a read of the
    // same word so back-to-back write then read returns the new value.
    logic [31:0] rd_raw;
    logic        rd_fwd;

    always_comb begin
        case (addr_low)
            `ADDR_CTRL:      rd_raw = {31'h00000000, enable_r};
            `ADDR_ON_THR1:   rd_raw = {16'h0000, on_thr_r[0]};
            `ADDR_ON_THR2:   rd_raw = {16'h0000, on_thr_r[1]};
            `ADDR_ON_THR3:   rd_raw = {16'h0000, on_thr_r[2]};
            `ADDR_OFF_THR1:  rd_raw = {16'h0000, off_thr_r[0]};
            `ADDR_OFF_THR2:  rd_raw = {16'h0000, off_thr_r[1]};
            `ADDR_OFF_THR3:  rd_raw = {16'h0000, off_thr_r[2]};
            `ADDR_ON_DELAY:  rd_raw = {16'h0000, on_delay_r};
            `ADDR_OFF_DELAY: rd_raw = {16'h0000, off_delay_r};
            `ADDR_STEP1:     rd_raw = {16'h0000, step_r[0]};
            `ADDR_STEP2:     rd_raw = {16'h0000, step_r[1]};
            `ADDR_STEP3:     rd_raw = {16'h0000, step_r[2]};
            `ADDR_SETPOINT:  rd_raw = {16'h0000, setpoint_r};
            `ADDR_STATUS:    rd_raw = {25'h0000000, 2'(state_r), aux_r, count_r};
            `ADDR_FREQ_OFS:  rd_raw = {{14{offset_r[17]}}, offset_r};
            default:         rd_raw = 32'h00000000;
        endcase
    end

    assign rd_fwd  = wr_pend_r & (wr_addr_r == addr_low) & (addr_low != `ADDR_STATUS)
                     & (addr_low != `ADDR_FREQ_OFS);
    assign rd_data = rd_fwd ? ((addr_low == `ADDR_CTRL) ? {31'h00000000, hwdata[`CTRL_EN_BIT]}
                                                         : {16'h0000, hwdata[15:0]})
                            : rd_raw;

    ////////////////////////////////////////////////////////////////////////////
    // Bus pipeline: zero wait states, always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            hrdata_r    <= 32'h00000000;
        end else begin
            wr_pend_r   <= wr_take;
            wr_addr_r   <= addr_low;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            if (rd_take) begin
                hrdata_r <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_r    <= 1'b0;
            on_delay_r  <= `RST_DELAY;
            off_delay_r <= `RST_DELAY;
            setpoint_r  <= `RST_SETPOINT;
        end else begin
            if (we_ctrl)    enable_r    <= hwdata[`CTRL_EN_BIT];
            if (we_on_dly)  on_delay_r  <= hwdata[15:0];
            if (we_off_dly) off_delay_r <= hwdata[15:0];
            if (we_setpt)   setpoint_r  <= hwdata[15:0];
        end
    end

    // Per-stage thresholds and reference steps, addressed by stage index.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 3; i++) begin
                on_thr_r[i]  <= `RST_ON_THR;
                off_thr_r[i] <= `RST_OFF_THR;
                step_r[i]    <= `RST_STEP;
            end
        end else begin
            if (we_on_thr)  on_thr_r[wr_idx]  <= hwdata[15:0];
            if (we_off_thr) off_thr_r[wr_idx] <= hwdata[15:0];
            if (we_step)    step_r[wr_idx]    <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond timebase for the delays.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end else begin
            tick_r     <= (tick_cnt_r == TICK_CYCLES - 16'h0001);
            tick_cnt_r <= (tick_cnt_r == TICK_CYCLES - 16'h0001) ? 16'h0000 : tick_cnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frequency comparisons for the next stage up and the current stage.

    logic [1:0]         up_idx;
    logic [1:0]         dn_idx;
    logic [15:0]        up_on;
    logic [15:0]        dn_on;
    logic [15:0]        dn_off;
    logic               can_add;
    logic               can_drop;
    logic               start_rise;
    logic               start_hold;
    logic               stop_fall;
    logic               stop_hold;
    logic signed [17:0] up_span;
    logic signed [17:0] dn_span;

    assign up_idx     = count_r;
    assign dn_idx     = count_r - 2'h1;
    assign up_on      = sel3(up_idx, on_thr_r[0], on_thr_r[1], on_thr_r[2]);
    assign dn_on      = sel3(dn_idx, on_thr_r[0], on_thr_r[1], on_thr_r[2]);
    assign dn_off     = sel3(dn_idx, off_thr_r[0], off_thr_r[1], off_thr_r[2]);
    assign can_add    = enable_r & (count_r != 2'h3);
    assign can_drop   = enable_r & (count_r != 2'h0);
    assign start_rise = can_add & above_band(out_freq, up_on);
    assign start_hold = can_add & ~below_band(out_freq, up_on) & (out_freq != up_on - 16'(`FREQ_HYST));
    assign stop_fall  = can_drop & below_band(out_freq, dn_off);
    assign stop_hold  = can_drop & ~above_band(out_freq, dn_off) & (out_freq != dn_off + 16'(`FREQ_HYST));
    assign up_span    = stage_span(up_on, sel3(up_idx, off_thr_r[0], off_thr_r[1], off_thr_r[2]));
    assign dn_span    = stage_span(dn_on, dn_off);

    ////////////////////////////////////////////////////////////////////////////
    // Delay timers for starting and stopping a motor.

    logic on_expired;
    logic off_expired;
    logic on_arm;
    logic off_arm;
    logic on_abort;
    logic off_abort;

    assign on_arm    = (state_r == staging_pkg::ST_IDLE) & start_rise;
    assign off_arm   = (state_r == staging_pkg::ST_IDLE) & ~start_rise & stop_fall;
    assign on_abort  = (state_r == staging_pkg::ST_WAIT_ON) & ~start_hold;
    assign off_abort = (state_r == staging_pkg::ST_WAIT_OFF) & ~stop_hold;

    staging_delay_timer u_on_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .arm     (on_arm),
        .abort   (on_abort),
        .tick    (tick_r),
        .delay   (on_delay_r),
        .expired (on_expired)
    );

    staging_delay_timer u_off_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .arm     (off_arm),
        .abort   (off_abort),
        .tick    (tick_r),
        .delay   (off_delay_r),
        .expired (off_expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: when enabled, arms a delay, then starts or stops exactly one motor; when disabled, stops them all at once.
    always_comb begin
        state_nxt  = state_r;
        count_nxt  = count_r;
        aux_nxt    = aux_r;
        offset_nxt = offset_r;
        case (state_r)
            staging_pkg::ST_IDLE: begin
                if (!enable_r) begin
                    count_nxt  = 2'h0;
                    aux_nxt    = 3'h0;
                    offset_nxt = 18'sh00000;
                end else if (on_arm) begin
                    state_nxt = staging_pkg::ST_WAIT_ON;
                end else if (off_arm) begin
                    state_nxt = staging_pkg::ST_WAIT_OFF;
                end
            end
            staging_pkg::ST_WAIT_ON: begin
                if (on_abort) begin
                    state_nxt = staging_pkg::ST_IDLE;
                end else if (on_expired) begin
                    state_nxt  = staging_pkg::ST_IDLE;
                    count_nxt  = count_r + 2'h1;
                    aux_nxt    = aux_r | (3'h1 << count_r);
                    offset_nxt = offset_r - up_span;
                end
            end
            staging_pkg::ST_WAIT_OFF: begin
                if (off_abort) begin
                    state_nxt = staging_pkg::ST_IDLE;
                end else if (off_expired) begin
                    state_nxt  = staging_pkg::ST_IDLE;
                    count_nxt  = count_r - 2'h1;
                    aux_nxt    = aux_r & ~(3'h1 << dn_idx);
                    offset_nxt = offset_r + dn_span;
                end
            end
            default: begin
                state_nxt = staging_pkg::ST_IDLE;
            end
        endcase
    end

    // Process reference: setpoint plus one step per running-motor level.
    assign ref_nxt = {2'b00, setpoint_r}
                     + ((count_r >= 2'h1) ? {2'b00, step_r[0]} : 18'h00000)
                     + ((count_r >= 2'h2) ? {2'b00, step_r[1]} : 18'h00000)
                     + ((count_r == 2'h3) ? {2'b00, step_r[2]} : 18'h00000);

    ////////////////////////////////////////////////////////////////////////////
    // Staging state registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r  <= staging_pkg::ST_IDLE;
            count_r  <= 2'h0;
            aux_r    <= 3'h0;
            offset_r <= 18'sh00000;
            ref_r    <= 18'h00000;
        end else begin
            state_r  <= state_nxt;
            count_r  <= count_nxt;
            aux_r    <= aux_nxt;
            offset_r <= offset_nxt;
            ref_r    <= ref_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop.
    assign hreadyout         = hreadyout_r;
    assign hresp             = hresp_r;
    assign hrdata            = hrdata_r;
    assign aux_motor_on      = aux_r;
    assign freq_offset       = offset_r;
    assign process_reference = ref_r;

endmodule : pump_fan_staging

// File: src/staging_delay_timer.sv
// Millisecond delay timer used for the staging start and stop delays.
// Assumes a one-cycle millisecond tick from the same clock domain.
module staging_delay_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        arm,
    input  wire logic        abort,
    input  wire logic        tick,
    input  wire logic [15:0] delay,
    output logic             expired
);

    logic        run_r;
    logic [15:0] count_r;
    logic        zero;

    // The timer has expired once it runs and its count is spent.
    assign zero    = (count_r == 16'h0000);
    assign expired = run_r & zero;

    ////////////////////////////////////////////////////////////////////////////
    // Arming loads the delay; abort or expiry stops the timer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r   <= 1'b0;
            count_r <= 16'h0000;
        end else if (arm) begin
            run_r   <= 1'b1;
            count_r <= delay;
        end else if (abort || expired) begin
            run_r   <= 1'b0;
            count_r <= 16'h0000;
        end else if (run_r && tick) begin
            count_r <= count_r - 16'h0001;
        end
    end

endmodule : staging_delay_timer

// File: src/staging_params.svh
// Constants of the pump and fan staging block: register offsets, reset values,
// field positions and timing figures.
// Assumes it is included by its bare name; it holds definitions only.
`ifndef STAGING_PARAMS_SVH
`define STAGING_PARAMS_SVH

// Widths of frequency, reference and low address values.
`define FREQ_W          16
`define REF_W           18
`define ADDR_LOW_W      8

// Register byte offsets on the AHB-Lite port.
`define ADDR_CTRL       8'h00
`define ADDR_ON_THR1    8'h04
`define ADDR_ON_THR2    8'h08
`define ADDR_ON_THR3    8'h0c
`define ADDR_OFF_THR1   8'h10
`define ADDR_OFF_THR2   8'h14
`define ADDR_OFF_THR3   8'h18
`define ADDR_ON_DELAY   8'h1c
`define ADDR_OFF_DELAY  8'h20
`define ADDR_STEP1      8'h24
`define ADDR_STEP2      8'h28
`define ADDR_STEP3      8'h2c
`define ADDR_SETPOINT   8'h30
`define ADDR_STATUS     8'h34
`define ADDR_FREQ_OFS   8'h38

// Reset values; frequencies in 0.1 Hz, percentages in 0.1 %, delays in ms.
`define RST_ON_THR      16'h01c2
`define RST_OFF_THR     16'h012c
`define RST_DELAY       16'h0064
`define RST_STEP        16'h0000
`define RST_SETPOINT    16'h01f4

// The 1 Hz hysteresis band, in 0.1 Hz units.
`define FREQ_HYST       17'h0000a

// Field positions.
`define CTRL_EN_BIT     0
`define STAT_AUX_LSB    2
`define STAT_STATE_LSB  5

// Transfer encodings used by the slave.
`define HSIZE_WORD      3'h2

// Delay timebase: one millisecond at a 25 ns clock period.
`define TICK_TIME_NS    1000000
`define CLK_PERIOD_NS   25

`endif

// File: src/staging_pkg.sv
// Types shared by the pump and fan staging block.
// Assumes nothing of its surroundings; nothing is imported from it.
package staging_pkg;

    // Sequencer states: idle, waiting to start a motor, waiting to stop one.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_ON,
        ST_WAIT_OFF
    } stage_state_type;

    // Frequency and percentage words.
    typedef logic [15:0] freq_type;

endpackage : staging_pkg
